// File: chan_ctl.sv
// one dma channel: control fields, address stepping, state report, pin routing
// assumes a classic wishbone master and a 125 MHz mclk
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module chan_ctl
  import chan_ctl_pkg::*;
#(
  parameter logic [2:0] CHAN_NUM = 3'h3
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // partner channel request-source bit (same clock)
  input  wire logic        partner_req_ext,
  // external handshake pins
  input  wire logic        ext_req_pin,
  output logic             ext_ack_pin,
  output logic             first_gpio_bank_sel,
  output logic             third_gpio_bank_sel,
  // internal peripheral handshake (same clock)
  input  wire logic        int_req,
  output logic             int_ack,
  // memory side of each transfer
  output logic      [31:0] mem_addr,
  output logic             mem_we,
  output logic             mem_strobe,
  output logic      [1:0]  mem_size,
  // fly-by data leaving the fifo
  output logic      [31:0] out_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  // fly-by data entering the fifo
  input  wire logic [31:0] in_data,
  input  wire logic        in_valid,
  output logic             in_ready
);

  typedef struct packed {
    logic        req_ext;
    logic        src_inh;
    logic        dst_inh;
    logic [1:0]  size;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [31:0] src_cur;
    logic [31:0] dst_cur;
    logic [31:0] dst_base;
    logic        dst_first;
    xfer_mode_e  mode;
    logic        go;
    chan_state_e state;
    logic [9:0]  index;
    logic        sync1;
    logic        sync2;
    logic [31:0] dat_o;
    logic        ack;
    logic        ext_ack;
    logic        first_sel;
    logic        third_sel;
    logic        int_ack;
    logic [31:0] mem_addr;
    logic        mem_we;
    logic        mem_strobe;
    logic [1:0]  eff_size;
  } chan_s;

  chan_s       chan_reg;
  chan_s       chan_next;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] wmask;
  logic        owns_port;
  logic        trig;
  logic [1:0]  op_size;
  logic [9:0]  step;
  logic        src_mem;
  logic        dst_mem;
  logic        size_active;
  logic [31:0] ctl_view;

  // fifo between the fly-by side and memory
  fifo_if #(.WIDTH(FIFO_WIDTH)) fill_if ();
  fifo_if #(.WIDTH(FIFO_WIDTH)) drain_if ();

  data_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk   (mclk),
    .resetn (resetn),
    .wr     (fill_if.snk),
    .rd     (drain_if.src)
  );

  // fifo hookup: fly-by writes fill, fly-by reads drain
  assign fill_if.valid  = in_valid && (chan_reg.mode == MODE_FLY_WRITE);
  assign fill_if.data   = in_data;
  assign drain_if.ready = out_ready && (chan_reg.mode == MODE_FLY_READ);

  // byte-lane write mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // control register as software reads it
  always_comb begin
    ctl_view                         = '0;
    ctl_view[REQ_SRC_BIT]            = chan_reg.req_ext;
    ctl_view[SRC_INH_BIT]            = chan_reg.src_inh;
    ctl_view[DST_INH_BIT]            = chan_reg.dst_inh;
    ctl_view[SIZE_LSB +: 2]          = chan_reg.size;
    ctl_view[STATE_LSB +: 6]         = chan_reg.state;
    ctl_view[INDEX_LSB +: 10]        = chan_reg.index;
  end

  // port ownership, sizing and stepping decisions
  always_comb begin
    // only channels of the two pairs may reach pins
    owns_port = 1'b0;
    if (chan_reg.req_ext) begin
      if (CHAN_NUM == CHAN_3 || CHAN_NUM == CHAN_4) begin
        owns_port = 1'b1;
      end else if (CHAN_NUM == CHAN_5 || CHAN_NUM == CHAN_6) begin
        owns_port = !partner_req_ext;
      end
    end
    trig = owns_port ? chan_reg.sync2 : int_req;
    // size applies on channel 3 external, or memory-to-memory
    size_active = (chan_reg.mode == MODE_M2M) ||
                  ((CHAN_NUM == CHAN_3) && chan_reg.req_ext);
    op_size = size_active ? chan_reg.size : SIZE_32;
    case (op_size)
      SIZE_32: step = STEP_4;
      SIZE_16: step = STEP_2;
      SIZE_8:  step = STEP_1;
      default: step = STEP_4;
    endcase
    src_mem = (chan_reg.mode != MODE_FLY_WRITE);
    dst_mem = (chan_reg.mode != MODE_FLY_READ);
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !chan_reg.ack;
  assign wb_wr  = wb_req && wb_we_i;

  // next-state logic
  always_comb begin
    chan_next            = chan_reg;
    chan_next.ack        = wb_req;
    chan_next.sync1      = ext_req_pin;
    chan_next.sync2      = chan_reg.sync1;
    chan_next.mem_strobe = 1'b0;
    chan_next.int_ack    = 1'b0;
    chan_next.ext_ack    = 1'b0;
    chan_next.first_sel  = owns_port && (CHAN_NUM == CHAN_3 || CHAN_NUM == CHAN_5);
    chan_next.third_sel  = owns_port && (CHAN_NUM == CHAN_4 || CHAN_NUM == CHAN_6);
    chan_next.eff_size   = op_size;

    // register reads
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        CTL_OFS:      chan_next.dat_o = ctl_view;
        SRC_ADDR_OFS: chan_next.dat_o = chan_reg.src_addr;
        DST_ADDR_OFS: chan_next.dat_o = chan_reg.dst_addr;
        MODE_OFS:     chan_next.dat_o = {27'h0, chan_reg.go, 2'h0,
                                         chan_reg.mode} |
                                        {21'h0, CHAN_NUM, 8'h00};
        CUR_ADDR_OFS: chan_next.dat_o = chan_reg.dst_cur;
        FIFO_OFS:     chan_next.dat_o = drain_if.data;
        default:      chan_next.dat_o = '0;
      endcase
    end

    // register writes; reserved bits masked off
    if (wb_wr) begin
      case (wb_adr_i)
        CTL_OFS: begin
          chan_next.req_ext = (wb_sel_i[2]) ? wb_dat_i[REQ_SRC_BIT] : chan_reg.req_ext;
          chan_next.src_inh = (wb_sel_i[2]) ? wb_dat_i[SRC_INH_BIT] : chan_reg.src_inh;
          chan_next.dst_inh = (wb_sel_i[2]) ? wb_dat_i[DST_INH_BIT] : chan_reg.dst_inh;
          chan_next.size    = (wb_sel_i[2]) ? wb_dat_i[SIZE_LSB +: 2] : chan_reg.size;
        end
        SRC_ADDR_OFS: chan_next.src_addr = (chan_reg.src_addr & ~wmask) | (wb_dat_i & wmask);
        DST_ADDR_OFS: chan_next.dst_addr = (chan_reg.dst_addr & ~wmask) | (wb_dat_i & wmask);
        MODE_OFS: begin
          if (wb_sel_i[0]) begin
            chan_next.mode = xfer_mode_e'(wb_dat_i[MODE_LSB +: 2]);
            chan_next.go   = wb_dat_i[GO_BIT];
          end
        end
        default: ;
      endcase
    end

    // channel state machine
    case (chan_reg.state)
      ST_IDLE: begin
        if (chan_reg.go) begin
          chan_next.state = ST_LOAD_SRC;
          chan_next.index = '0;
        end
      end
      ST_LOAD_SRC: begin
        chan_next.src_cur = chan_reg.src_addr;
        chan_next.state   = ST_LOAD_DST;
      end
      ST_LOAD_DST: begin
        chan_next.dst_cur   = chan_reg.dst_addr;
        chan_next.dst_base  = chan_reg.dst_addr;
        chan_next.dst_first = 1'b1;
        chan_next.state     = ST_FIRST;
      end
      ST_FIRST: begin
        if (!chan_reg.go) begin
          chan_next.state = ST_UPDATE;
        end else if (chan_reg.mode == MODE_M2M) begin
          // read operand from source memory
          chan_next.mem_addr   = chan_reg.src_cur;
          chan_next.mem_we     = 1'b0;
          chan_next.mem_strobe = 1'b1;
          if (!chan_reg.src_inh) begin
            chan_next.src_cur = chan_reg.src_cur + {22'h000000, step};
          end
          chan_next.state = ST_SECOND;
        end else if (trig && ((src_mem && fill_if.ready) || (dst_mem && drain_if.valid))) begin
          // fly-by: memory address steps, the port side never does
          chan_next.mem_strobe = 1'b1;
          chan_next.int_ack    = !owns_port;
          chan_next.ext_ack    = owns_port;
          chan_next.index      = chan_reg.index + step;
          if (src_mem) begin
            chan_next.mem_addr = chan_reg.src_cur;
            chan_next.mem_we   = 1'b0;
            if (!chan_reg.src_inh) begin
              chan_next.src_cur = chan_reg.src_cur + {22'h000000, step};
            end
          end else begin
            chan_next.mem_addr = chan_reg.dst_cur;
            chan_next.mem_we   = 1'b1;
            if (!chan_reg.dst_inh) begin
              chan_next.dst_cur = chan_reg.dst_cur + {22'h000000, step};
            end
          end
        end
      end
      ST_SECOND: begin
        // write operand to destination memory
        chan_next.mem_addr   = chan_reg.dst_cur;
        chan_next.mem_we     = 1'b1;
        chan_next.mem_strobe = 1'b1;
        chan_next.index      = chan_reg.index + step;
        if (!chan_reg.dst_inh && chan_reg.dst_first) begin
          chan_next.dst_cur = chan_reg.dst_base + M2M_DST_STEP;
        end
        chan_next.dst_first = 1'b0;
        chan_next.state     = ST_FIRST;
      end
      ST_UPDATE: begin
        chan_next.state = ST_IDLE;
      end
      default: chan_next.state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chan_reg       <= '0;
      chan_reg.mode  <= MODE_FLY_READ;
      chan_reg.state <= ST_IDLE;
    end else begin
      chan_reg <= chan_next;
    end
  end

  // outputs straight from flops (fifo ready/valid are flop-driven too)
  assign wb_dat_o            = chan_reg.dat_o;
  assign wb_ack_o            = chan_reg.ack;
  assign ext_ack_pin         = chan_reg.ext_ack;
  assign first_gpio_bank_sel = chan_reg.first_sel;
  assign third_gpio_bank_sel = chan_reg.third_sel;
  assign int_ack             = chan_reg.int_ack;
  assign mem_addr            = chan_reg.mem_addr;
  assign mem_we              = chan_reg.mem_we;
  assign mem_strobe          = chan_reg.mem_strobe;
  assign mem_size            = chan_reg.eff_size;
  assign out_data            = drain_if.data;
  assign out_valid           = drain_if.valid && (chan_reg.mode == MODE_FLY_READ);
  assign in_ready            = fill_if.ready && (chan_reg.mode == MODE_FLY_WRITE);
endmodule

// File: chan_ctl_pkg.sv
// channel control field package: register layout, encodings, states
// assumes a 32-bit classic wishbone slave with word-aligned registers
package chan_ctl_pkg;

  // register map (byte addresses)
  localparam logic [7:0]  CTL_OFS        = 8'h00;
  localparam logic [7:0]  SRC_ADDR_OFS   = 8'h04;
  localparam logic [7:0]  DST_ADDR_OFS   = 8'h08;
  localparam logic [7:0]  MODE_OFS       = 8'h0c;
  localparam logic [7:0]  CUR_ADDR_OFS   = 8'h10;
  localparam logic [7:0]  FIFO_OFS       = 8'h14;

  // control register field positions
  localparam int          REQ_SRC_BIT    = 23;
  localparam int          SRC_INH_BIT    = 21;
  localparam int          DST_INH_BIT    = 20;
  localparam int          SIZE_LSB       = 16;
  localparam int          STATE_LSB      = 10;
  localparam int          INDEX_LSB      = 0;
  localparam logic [31:0] CTL_WMASK      = 32'h00b30000;

  // reset values
  localparam logic [31:0] CTL_RESET      = 32'h00000000;
  localparam logic [31:0] ADDR_RESET     = 32'h00000000;

  // operand size encodings
  localparam logic [1:0]  SIZE_32        = 2'h0;
  localparam logic [1:0]  SIZE_16        = 2'h1;
  localparam logic [1:0]  SIZE_8         = 2'h2;

  // step sizes in bytes
  localparam logic [9:0]  STEP_4         = 10'h004;
  localparam logic [9:0]  STEP_2         = 10'h002;
  localparam logic [9:0]  STEP_1         = 10'h001;
  localparam logic [31:0] M2M_DST_STEP   = 32'h00000004;

  // fifo shape
  localparam int          FIFO_WIDTH     = 32;
  localparam int          FIFO_DEPTH     = 4;

  // transfer modes held in the mode register
  typedef enum logic [1:0] {
    MODE_FLY_READ  = 2'b00,
    MODE_FLY_WRITE = 2'b01,
    MODE_M2M       = 2'b10
  } xfer_mode_e;

  // channel state codes as software sees them: idle is all zeros, the others one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000000,
    ST_LOAD_SRC = 6'b000001,
    ST_LOAD_DST = 6'b000100,
    ST_FIRST    = 6'b001000,
    ST_SECOND   = 6'b010000,
    ST_UPDATE   = 6'b100000
  } chan_state_e;

  // mode register fields
  localparam int          MODE_LSB       = 0;
  localparam int          GO_BIT         = 4;
  localparam int          CHAN_LSB       = 8;

  // channel numbers that own the multiplexed handshake pins
  localparam logic [2:0]  CHAN_3         = 3'h3;
  localparam logic [2:0]  CHAN_4         = 3'h4;
  localparam logic [2:0]  CHAN_5         = 3'h5;
  localparam logic [2:0]  CHAN_6         = 3'h6;

endpackage

// File: fifo_if.sv
// valid/ready stream carrier between the channel and its data fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: data_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fill and drain sides
  fifo_if.snk      wr,
  fifo_if.src      rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 count;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
  } fifo_s;

  fifo_s fifo_reg;
  fifo_s fifo_next;
  logic  push;
  logic  pop;

  // handshakes and pointer update
  always_comb begin
    fifo_next = fifo_reg;
    push      = wr.valid && (fifo_reg.count != DEPTH[AW:0]);
    pop       = rd.ready && (fifo_reg.count != '0);
    if (push) begin
      fifo_next.mem[fifo_reg.wptr] = wr.data;
      fifo_next.wptr               = fifo_reg.wptr + 1'b1;
    end
    if (pop) begin
      fifo_next.rptr = fifo_reg.rptr + 1'b1;
    end
    fifo_next.count = fifo_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  assign wr.ready = (fifo_reg.count != DEPTH[AW:0]); // honest full
  assign rd.valid = (fifo_reg.count != '0);          // honest empty
  assign rd.data  = fifo_reg.mem[fifo_reg.rptr];
endmodule

// File: mem_peer.sv
// far-side model: internal peripheral trigger, fly-by producer and consumer
// assumes the channel samples these lines on the rising edge of mclk
`timescale 1ns/1ps
module mem_peer (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // trigger enable from the bench
  input  wire logic        int_en,
  // lines toward the channel
  output logic             int_req,
  output logic             ext_req_pin,
  output logic             out_ready,
  output logic             in_valid,
  output logic      [31:0] in_data,
  input  wire logic        in_ready
);
  logic [1:0] cnt;
  // producer always offers a word; the consumer stalls one cycle in four
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt         <= 2'h0;
      int_req     <= 1'b0;
      ext_req_pin <= 1'b0;
      out_ready   <= 1'b0;
      in_valid    <= 1'b0;
      in_data     <= 32'h00000000;
    end else begin
      cnt         <= cnt + 2'h1;
      int_req     <= int_en;
      ext_req_pin <= int_en;
      out_ready   <= (cnt != 2'h3);
      in_valid    <= 1'b1;
      if (in_valid && in_ready) begin
        in_data <= in_data + 32'h00000001; // next word only after a handshake
      end
    end
  end
endmodule

// File: chan_ctl_props.sv
// concurrent checks on the channel's ports
// assumes one mclk domain and the active-low resetn
`timescale 1ns/1ps
module chan_ctl_props
  import chan_ctl_pkg::*;
#(
  parameter logic [2:0] CHAN_NUM = 3'h3
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // handshakes and pins
  input wire logic        partner_req_ext,
  input wire logic        ext_req_pin,
  input wire logic        ext_ack_pin,
  input wire logic        first_gpio_bank_sel,
  input wire logic        third_gpio_bank_sel,
  input wire logic        int_req,
  input wire logic        int_ack,
  // memory and fly-by
  input wire logic [31:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        mem_strobe,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] out_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [31:0] in_data,
  input wire logic        in_valid,
  input wire logic        in_ready
);
  logic        rd_ack;
  logic        req_sh;
  logic        inh_sh;
  logic        rd_seen;
  logic [31:0] rd_last;
  logic [31:0] step;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // read answer qualifier and expected source step by operand size
  assign rd_ack = wb_ack_o && !wb_we_i && wb_cyc_i;
  assign step = (mem_size == SIZE_16) ? 32'h2 : (mem_size == SIZE_8) ? 32'h1 : 32'h4;
  // shadow of written control bits and last memory read address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_sh  <= 1'b0;
      inh_sh  <= 1'b0;
      rd_seen <= 1'b0;
      rd_last <= 32'h00000000;
    end else begin
      if (wb_ack_o && wb_we_i && wb_cyc_i && wb_adr_i == CTL_OFS && wb_sel_i[2]) begin
        req_sh <= wb_dat_i[REQ_SRC_BIT];
        inh_sh <= wb_dat_i[SRC_INH_BIT];
      end
      if (wb_cyc_i && wb_we_i) begin
        rd_seen <= 1'b0; // new setup restarts the step chain
      end else if (mem_strobe && !mem_we) begin
        rd_seen <= 1'b1;
        rd_last <= mem_addr;
      end
    end
  end
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_resv_read_zero: assert property (rd_ack && wb_adr_i == CTL_OFS |-> (wb_dat_o & 32'hff4c0000) == 0)
    else $error("reserved control bits read nonzero");
  a_state_one_hot: assert property (rd_ack && wb_adr_i == CTL_OFS |-> wb_dat_o[15:10] inside {6'h00, 6'h01, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("state field not a legal code");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i > FIFO_OFS |-> wb_dat_o == 32'h0)
    else $error("unmapped address read nonzero");
  a_third_bank_take: assert property ($rose(req_sh) && CHAN_NUM == CHAN_4 |-> ##[1:4] third_gpio_bank_sel)
    else $error("channel did not take third bank port");
  a_first_bank_owner: assert property (first_gpio_bank_sel |-> CHAN_NUM == CHAN_3 || CHAN_NUM == CHAN_5)
    else $error("first bank driven by wrong channel");
  a_third_bank_owner: assert property (third_gpio_bank_sel |-> CHAN_NUM == CHAN_4 || CHAN_NUM == CHAN_6)
    else $error("third bank driven by wrong channel");
  a_src_step_size: assert property (mem_strobe && !mem_we && rd_seen |-> mem_addr == rd_last + (inh_sh ? 32'h0 : step))
    else $error("source pointer stepped wrongly");
  // main scenarios
  c_mem_write: cover property (mem_strobe && mem_we);
  c_third_bank: cover property (third_gpio_bank_sel);
  c_int_ack: cover property (int_ack);
endmodule

bind chan_ctl chan_ctl_props #(.CHAN_NUM(CHAN_NUM)) i_props (
  .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .partner_req_ext(partner_req_ext), .ext_req_pin(ext_req_pin),
  .ext_ack_pin(ext_ack_pin), .first_gpio_bank_sel(first_gpio_bank_sel),
  .third_gpio_bank_sel(third_gpio_bank_sel), .int_req(int_req), .int_ack(int_ack),
  .mem_addr(mem_addr), .mem_we(mem_we), .mem_strobe(mem_strobe), .mem_size(mem_size),
  .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .in_data(in_data),
  .in_valid(in_valid), .in_ready(in_ready));

// File: tb_top.sv
// register-level bench for one channel set up as channel 4
// assumes mem_peer stands on the fly-by and trigger side
`timescale 1ns/1ps
module tb_top
  import chan_ctl_pkg::*;
;
  logic        mclk = 1'b0, resetn = 1'b0, int_en = 1'b0, partner_req_ext = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, mem_we, mem_strobe;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wd = 32'h0, wb_rd, q, mem_addr, out_data, in_data;
  logic [1:0]  mem_size;
  logic        ext_req, ext_ack, bank1, bank3, int_req, int_ack, ov, ordy, iv, irdy;
  logic [31:0] addr_q [4];
  logic [1:0]  sz_q [4];
  int          num_errors = 0, checks_done = 0;
  always #4 mclk = ~mclk;
  chan_ctl #(.CHAN_NUM(CHAN_4)) i_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .partner_req_ext(partner_req_ext),
    .ext_req_pin(ext_req), .ext_ack_pin(ext_ack), .first_gpio_bank_sel(bank1),
    .third_gpio_bank_sel(bank3), .int_req(int_req), .int_ack(int_ack), .mem_addr(mem_addr),
    .mem_we(mem_we), .mem_strobe(mem_strobe), .mem_size(mem_size), .out_data(out_data),
    .out_valid(ov), .out_ready(ordy), .in_data(in_data), .in_valid(iv), .in_ready(irdy));
  mem_peer i_peer (.mclk(mclk), .resetn(resetn), .int_en(int_en), .int_req(int_req),
    .ext_req_pin(ext_req), .out_ready(ordy), .in_valid(iv), .in_data(in_data), .in_ready(irdy));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wd <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = wb_rd;
    if (k >= 50) check(1'b0, 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  // record address and size of the next cnt memory strobes of one direction
  task automatic collect(input logic we, input int cnt);
    int i, k;
    i = 0;
    for (k = 0; k < 400 && i < cnt; k++) begin
      @(posedge mclk);
      if (mem_strobe === 1'b1 && mem_we === we) begin
        addr_q[i] = mem_addr;
        sz_q[i] = mem_size;
        i++;
      end
    end
    check(i, cnt);
  endtask
  // clear go and wait for the idle state
  task automatic halt();
    int k;
    wb(1'b1, MODE_OFS, 32'h0);
    for (k = 0; k < 20; k++) begin
      wb(1'b0, CTL_OFS, 32'h0);
      if (q[15:10] === ST_IDLE) break;
    end
    check(q[15:10], ST_IDLE);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, CTL_OFS, 32'h0);
    check(q, CTL_RESET);
    wb(1'b0, MODE_OFS, 32'h0);
    check(q[10:8], CHAN_4);
    wb(1'b0, 8'h18, 32'h0);
    check(q, 32'h0);
    // all ones: only writable fields stick, external source wins the bank
    partner_req_ext <= 1'b1;
    wb(1'b1, CTL_OFS, 32'hffffffff);
    wb(1'b0, CTL_OFS, 32'h0);
    check(q, CTL_WMASK);
    repeat (4) @(posedge mclk);
    check(bank3, 1'b1);
    check(bank1, 1'b0);
    partner_req_ext <= 1'b0;
    int_en <= 1'b1;
    // fly-by read, stepping and held source; size and dest step ignored
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, SRC_ADDR_OFS, 32'h100);
      wb(1'b1, CTL_OFS, (32'(i) << SRC_INH_BIT) | (32'h1 << DST_INH_BIT) | 32'h00020000);
      wb(1'b1, MODE_OFS, 32'(MODE_FLY_READ) | (32'h1 << GO_BIT));
      collect(1'b0, 3);
      for (int k = 0; k < 3; k++) check(addr_q[k], 32'h100 + (i ? 0 : 4 * k));
      check(sz_q[0], SIZE_32);
      halt();
    end
    // fly-by write: fill the fifo with no trigger, then trigger memory writes while the fifo stays full
    int_en <= 1'b0;
    wb(1'b1, DST_ADDR_OFS, 32'h200);
    wb(1'b1, CTL_OFS, 32'h1 << SRC_INH_BIT);
    wb(1'b1, MODE_OFS, 32'(MODE_FLY_WRITE) | (32'h1 << GO_BIT));
    // filling starts one edge after the edge that takes the mode write, so count at the producer
    repeat (20) @(posedge mclk);
    check(in_data, FIFO_DEPTH);
    check(irdy, 1'b0);
    check(out_data, 32'h0);
    int_en <= 1'b1;
    collect(1'b1, 4);
    for (int k = 0; k < 4; k++) check(addr_q[k], 32'h200 + 4 * k);
    halt();
    // memory to memory, byte operands, destination steps once then holds
    wb(1'b1, SRC_ADDR_OFS, 32'h300);
    wb(1'b1, DST_ADDR_OFS, 32'h400);
    wb(1'b1, CTL_OFS, 32'(SIZE_8) << SIZE_LSB);
    wb(1'b1, MODE_OFS, 32'(MODE_M2M) | (32'h1 << GO_BIT));
    collect(1'b1, 3);
    check(addr_q[0], 32'h400);
    check(addr_q[1], 32'h400 + M2M_DST_STEP);
    check(addr_q[2], 32'h400 + M2M_DST_STEP);
    check(sz_q[1], SIZE_8);
    halt();
    final_report();
  end
endmodule
